/* logic/rts_pkg.sv */
// Constants, register map and state type of the reset and time-out sequencer
`default_nettype none

package rts_pkg;

  // ------------------------------------------------------------------
  // Clock rates and time-outs
  // ------------------------------------------------------------------
  localparam int unsigned CLK_HZ = 200_000_000;
  localparam int unsigned LF_HZ = 31_000;
  localparam int unsigned LF_DIV_CYC = CLK_HZ / LF_HZ;
  localparam int unsigned POWER_UP_TIMER_MS = 64;
  localparam logic [10:0] POWER_UP_TIMER_TICKS = 11'(POWER_UP_TIMER_MS * LF_HZ / 1000);
  localparam logic [10:0] OST_PERIODS = 11'h400;
  localparam int unsigned BOD_MIN_NS = 100;
  localparam logic [7:0] BOD_MIN_CYC = 8'((BOD_MIN_NS * (CLK_HZ / 1_000_000) + 999) / 1000);

  // ------------------------------------------------------------------
  // Register offsets
  // ------------------------------------------------------------------
  localparam logic [7:0] ADDR_STATUS = 8'h83;
  localparam logic [7:0] ADDR_POWER_CONTROL = 8'h8E;
  localparam logic [7:0] ADDR_CFG_LO = 8'hF0;
  localparam logic [7:0] ADDR_CFG_HI = 8'hF1;

  // ------------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------------
  localparam int unsigned PC_BROWNOUT_FLAG_N = 0;
  localparam int unsigned PC_POWERON_FLAG_N = 1;
  localparam int unsigned PC_SW_BROWNOUT_ENABLE = 4;
  localparam int unsigned PC_ULP_WAKEUP_ENABLE = 5;
  localparam int unsigned ST_POWERDOWN_FLAG_N = 3;
  localparam int unsigned ST_TIMEOUT_FLAG_N = 4;
  localparam int unsigned CFG_OSC_SEL_LSB = 0;
  localparam int unsigned CFG_POWER_TIMER_DISABLE = 4;
  localparam int unsigned CFG_MASTER_CLEAR_ENABLE = 5;
  localparam int unsigned CFG_BROWNOUT_MODE_LSB = 8;
  localparam int unsigned CFG_TWO_SPEED_STARTUP = 10;
  localparam int unsigned CFG_FAIL_SAFE_MONITOR = 11;

  // ------------------------------------------------------------------
  // Values after power-on reset
  // ------------------------------------------------------------------
  localparam logic RST_BROWNOUT_FLAG_N = 1'b0;
  localparam logic RST_POWERON_FLAG_N = 1'b0;
  localparam logic RST_SW_BROWNOUT_ENABLE = 1'b1;
  localparam logic RST_ULP_WAKEUP_ENABLE = 1'b0;
  localparam logic RST_TIMEOUT_FLAG_N = 1'b1;
  localparam logic RST_POWERDOWN_FLAG_N = 1'b1;

  // ------------------------------------------------------------------
  // Codes
  // ------------------------------------------------------------------
  localparam logic [1:0] BOD_MODE_OFF = 2'h0;
  localparam logic [1:0] BOD_MODE_SW = 2'h1;
  localparam logic [1:0] BOD_MODE_NOSLEEP = 2'h2;
  localparam logic [1:0] BOD_MODE_ON = 2'h3;
  localparam logic [2:0] OSC_LP = 3'h0;
  localparam logic [2:0] OSC_XT = 3'h1;
  localparam logic [2:0] OSC_HS = 3'h2;

  typedef enum logic [1:0] {
    RTS_SUPPLY,
    RTS_POWER_UP_TIMER,
    RTS_OST,
    RTS_RUN
  } rts_state_t;

endpackage

`default_nettype wire

/* logic/rts_reset_timeout_sequencer.sv */
// Reset sequencer: power-up and start-up timers, brown-out modes, cause flags
`timescale 1ns/10ps
`default_nettype none

module rts_reset_timeout_sequencer #(
  parameter int unsigned P_LF_DIV_CYC = rts_pkg::LF_DIV_CYC
) (
  input wire logic i_clk_sys,
  input wire logic i_arst_n,
  input wire logic [15:0] i_cfg_word,
  input wire logic i_master_clear_n,
  input wire logic i_bod_low,
  input wire logic i_osc_clk,
  input wire logic i_wdt_timeout,
  input wire logic i_sleep,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  output logic o_core_rst_n,
  output logic o_osc_stable,
  output logic o_run_on_internal_oscillator,
  output logic o_bod_enable
);

  // ------------------------------------------------------------------
  // Reset release and pin synchronisers
  // ------------------------------------------------------------------
  logic [1:0] rst_sync_r;
  logic rst_n;
  logic [1:0] master_clear_n_sync_r;
  logic master_clear_n_d_r;
  logic [1:0] bod_sync_r;
  logic [1:0] osc_sync_r;
  logic osc_d_r;

  always_ff @(posedge i_clk_sys or negedge i_arst_n)
  begin
    if (!i_arst_n)
      rst_sync_r <= 2'h0;
    else
      rst_sync_r <= {rst_sync_r[0], 1'b1};
  end

  assign rst_n = rst_sync_r[1];

  always_ff @(posedge i_clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      master_clear_n_sync_r <= 2'h3;
      master_clear_n_d_r <= 1'b1;
      bod_sync_r <= 2'h0;
      osc_sync_r <= 2'h0;
      osc_d_r <= 1'b0;
    end
    else
    begin
      master_clear_n_sync_r <= {master_clear_n_sync_r[0], i_master_clear_n};
      master_clear_n_d_r <= master_clear_n_sync_r[1];
      bod_sync_r <= {bod_sync_r[0], i_bod_low};
      osc_sync_r <= {osc_sync_r[0], i_osc_clk};
      osc_d_r <= osc_sync_r[1];
    end
  end

  // ------------------------------------------------------------------
  // Configuration decode
  // ------------------------------------------------------------------
  function automatic logic is_crystal(input logic [2:0] sel);
    is_crystal = (sel == rts_pkg::OSC_LP) || (sel == rts_pkg::OSC_XT) ||
      (sel == rts_pkg::OSC_HS);
  endfunction

  function automatic logic bod_active(input logic [1:0] mode, input logic sw_en,
                                      input logic asleep);
    unique case (mode)
      rts_pkg::BOD_MODE_OFF: bod_active = 1'b0;
      rts_pkg::BOD_MODE_SW: bod_active = sw_en;
      rts_pkg::BOD_MODE_NOSLEEP: bod_active = !asleep;
      rts_pkg::BOD_MODE_ON: bod_active = 1'b1;
    endcase
  endfunction

  logic [2:0] osc_sel;
  logic power_up_timer_en;
  logic crystal;
  logic early_run;
  logic master_clear_n_low;
  logic master_clear_n_fall;
  logic osc_rise;
  logic sw_brownout_enable_r;
  logic bod_en;

  assign osc_sel = i_cfg_word[rts_pkg::CFG_OSC_SEL_LSB +: 3];
  assign power_up_timer_en = !i_cfg_word[rts_pkg::CFG_POWER_TIMER_DISABLE];
  assign crystal = is_crystal(osc_sel);
  assign early_run = i_cfg_word[rts_pkg::CFG_TWO_SPEED_STARTUP] ||
    i_cfg_word[rts_pkg::CFG_FAIL_SAFE_MONITOR];
  // With the pin function off, master clear is tied inactive inside
  assign master_clear_n_low = i_cfg_word[rts_pkg::CFG_MASTER_CLEAR_ENABLE] && !master_clear_n_sync_r[1];
  assign master_clear_n_fall = i_cfg_word[rts_pkg::CFG_MASTER_CLEAR_ENABLE] && master_clear_n_d_r &&
    !master_clear_n_sync_r[1];
  assign osc_rise = osc_sync_r[1] && !osc_d_r;
  assign bod_en = bod_active(i_cfg_word[rts_pkg::CFG_BROWNOUT_MODE_LSB +: 2],
    sw_brownout_enable_r, i_sleep);

  // ------------------------------------------------------------------
  // Brown-out filter
  // ------------------------------------------------------------------
  logic [7:0] bod_cnt_r;
  logic bor_evt;

  // A dip must outlast the minimum duration; shorter ones are ignored
  always_ff @(posedge i_clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      bod_cnt_r <= 8'h00;
    else if (!(bod_en && bod_sync_r[1]))
      bod_cnt_r <= 8'h00;
    else if (bod_cnt_r <= rts_pkg::BOD_MIN_CYC)
      bod_cnt_r <= bod_cnt_r + 8'h01;
  end

  assign bor_evt = (bod_cnt_r == rts_pkg::BOD_MIN_CYC) && bod_en && bod_sync_r[1];

  // ------------------------------------------------------------------
  // Low-frequency tick divider
  // ------------------------------------------------------------------
  logic [15:0] lf_div_r;
  logic lf_tick_r;

  always_ff @(posedge i_clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      lf_div_r <= 16'h0000;
      lf_tick_r <= 1'b0;
    end
    else if (lf_div_r == 16'(P_LF_DIV_CYC - 1))
    begin
      lf_div_r <= 16'h0000;
      lf_tick_r <= 1'b1;
    end
    else
    begin
      lf_div_r <= lf_div_r + 16'h0001;
      lf_tick_r <= 1'b0;
    end
  end

  // ------------------------------------------------------------------
  // Sequencer
  // ------------------------------------------------------------------
  rts_pkg::rts_state_t state_r;
  rts_pkg::rts_state_t state_nxt;
  logic [10:0] power_up_timer_cnt_r;
  logic [10:0] ost_cnt_r;
  logic power_up_timer_done;
  logic ost_done;
  logic sleep_d_r;
  logic wake;
  logic wake_ost_r;

  assign power_up_timer_done = lf_tick_r && (power_up_timer_cnt_r == rts_pkg::POWER_UP_TIMER_TICKS - 11'h001);
  assign ost_done = osc_rise && (ost_cnt_r == rts_pkg::OST_PERIODS - 11'h001);
  assign wake = sleep_d_r && !i_sleep;

  always_comb
  begin
    state_nxt = state_r;
    unique case (state_r)
      // Only power-on and brown-out land here, so the timer runs only then
      rts_pkg::RTS_SUPPLY:
        if (!(bod_en && bod_sync_r[1]))
        begin
          if (power_up_timer_en)
            state_nxt = rts_pkg::RTS_POWER_UP_TIMER;
          else if (crystal)
            state_nxt = rts_pkg::RTS_OST;
          else
            state_nxt = rts_pkg::RTS_RUN;
        end
      rts_pkg::RTS_POWER_UP_TIMER:
        if (bor_evt)
          state_nxt = rts_pkg::RTS_SUPPLY;
        else if (power_up_timer_done)
          state_nxt = crystal ? rts_pkg::RTS_OST : rts_pkg::RTS_RUN;
      rts_pkg::RTS_OST:
        if (bor_evt)
          state_nxt = rts_pkg::RTS_SUPPLY;
        else if (ost_done)
          state_nxt = rts_pkg::RTS_RUN;
      rts_pkg::RTS_RUN:
        if (bor_evt)
          state_nxt = rts_pkg::RTS_SUPPLY;
    endcase
  end

  always_ff @(posedge i_clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      state_r <= rts_pkg::RTS_SUPPLY;
    else
      state_r <= state_nxt;
  end

  always_ff @(posedge i_clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      power_up_timer_cnt_r <= 11'h000;
    else if (state_r != rts_pkg::RTS_POWER_UP_TIMER || bor_evt)
      power_up_timer_cnt_r <= 11'h000;
    else if (lf_tick_r)
      power_up_timer_cnt_r <= power_up_timer_cnt_r + 11'h001;
  end

  // Wake from sleep in a crystal mode reruns the start-up count
  always_ff @(posedge i_clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sleep_d_r <= 1'b0;
      wake_ost_r <= 1'b0;
    end
    else
    begin
      sleep_d_r <= i_sleep;
      if (wake && crystal && state_r == rts_pkg::RTS_RUN)
        wake_ost_r <= 1'b1;
      else if (ost_done || state_r != rts_pkg::RTS_RUN)
        wake_ost_r <= 1'b0;
    end
  end

  always_ff @(posedge i_clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      ost_cnt_r <= 11'h000;
    else if (state_r != rts_pkg::RTS_OST && !wake_ost_r)
      ost_cnt_r <= 11'h000;
    else if (osc_rise)
      ost_cnt_r <= ost_cnt_r + 11'h001;
  end

  // ------------------------------------------------------------------
  // Core reset and clock status outputs
  // ------------------------------------------------------------------
  logic seq_ready;

  // Timers run regardless of master clear, so a late release starts at once
  assign seq_ready = (state_r == rts_pkg::RTS_RUN) ||
    (state_r == rts_pkg::RTS_OST && early_run && !bor_evt);

  always_ff @(posedge i_clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      o_core_rst_n <= 1'b0;
      o_osc_stable <= 1'b0;
      o_run_on_internal_oscillator <= 1'b0;
      o_bod_enable <= 1'b0;
    end
    else
    begin
      // Watchdog in sleep wakes the core, elsewhere it resets it for one cycle
      o_core_rst_n <= seq_ready && (state_nxt != rts_pkg::RTS_SUPPLY) && !master_clear_n_low &&
        !(i_wdt_timeout && !i_sleep);
      o_osc_stable <= (state_r == rts_pkg::RTS_RUN) && !wake_ost_r;
      o_run_on_internal_oscillator <= early_run && (state_r == rts_pkg::RTS_OST || wake_ost_r);
      o_bod_enable <= bod_en;
    end
  end

  // ------------------------------------------------------------------
  // Cause flags and power control register
  // ------------------------------------------------------------------
  logic brownout_flag_n_r;
  logic poweron_flag_n_r;
  logic ulp_wakeup_enable_r;
  logic timeout_flag_n_r;
  logic powerdown_flag_n_r;
  logic pc_wr;
  logic other_rst;

  assign pc_wr = i_wr && (i_addr == rts_pkg::ADDR_POWER_CONTROL);
  assign other_rst = (i_wdt_timeout && !i_sleep) || master_clear_n_fall;

  // Hardware events are applied after the write so that they win over it
  always_ff @(posedge i_clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      brownout_flag_n_r <= rts_pkg::RST_BROWNOUT_FLAG_N;
      poweron_flag_n_r <= rts_pkg::RST_POWERON_FLAG_N;
      sw_brownout_enable_r <= rts_pkg::RST_SW_BROWNOUT_ENABLE;
      ulp_wakeup_enable_r <= rts_pkg::RST_ULP_WAKEUP_ENABLE;
    end
    else
    begin
      if (pc_wr)
      begin
        brownout_flag_n_r <= i_wdata[rts_pkg::PC_BROWNOUT_FLAG_N];
        poweron_flag_n_r <= i_wdata[rts_pkg::PC_POWERON_FLAG_N];
        sw_brownout_enable_r <= i_wdata[rts_pkg::PC_SW_BROWNOUT_ENABLE];
        ulp_wakeup_enable_r <= i_wdata[rts_pkg::PC_ULP_WAKEUP_ENABLE];
      end
      if (bor_evt)
      begin
        brownout_flag_n_r <= 1'b0;
        sw_brownout_enable_r <= rts_pkg::RST_SW_BROWNOUT_ENABLE;
        ulp_wakeup_enable_r <= rts_pkg::RST_ULP_WAKEUP_ENABLE;
      end
      else if (other_rst)
        ulp_wakeup_enable_r <= rts_pkg::RST_ULP_WAKEUP_ENABLE;
    end
  end

  always_ff @(posedge i_clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      timeout_flag_n_r <= rts_pkg::RST_TIMEOUT_FLAG_N;
      powerdown_flag_n_r <= rts_pkg::RST_POWERDOWN_FLAG_N;
    end
    else if (bor_evt)
    begin
      timeout_flag_n_r <= 1'b1;
      powerdown_flag_n_r <= 1'b1;
    end
    else if (i_wdt_timeout)
    begin
      timeout_flag_n_r <= 1'b0;
      if (i_sleep)
        powerdown_flag_n_r <= 1'b0;
    end
    else if (master_clear_n_fall && i_sleep)
    begin
      timeout_flag_n_r <= 1'b1;
      powerdown_flag_n_r <= 1'b0;
    end
    else if (i_sleep && !sleep_d_r)
    begin
      timeout_flag_n_r <= 1'b1;
      powerdown_flag_n_r <= 1'b0;
    end
  end

  // ------------------------------------------------------------------
  // Register read port
  // ------------------------------------------------------------------
  always_ff @(posedge i_clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      o_rdata <= 8'h00;
    else if (!i_rd)
      o_rdata <= 8'h00;
    else
    begin
      unique case (i_addr)
        rts_pkg::ADDR_POWER_CONTROL:
          o_rdata <= {2'h0, ulp_wakeup_enable_r, sw_brownout_enable_r, 2'h0,
            poweron_flag_n_r, brownout_flag_n_r};
        rts_pkg::ADDR_STATUS:
          o_rdata <= {3'h0, timeout_flag_n_r, powerdown_flag_n_r, 3'h0};
        rts_pkg::ADDR_CFG_LO:
          o_rdata <= i_cfg_word[7:0];
        rts_pkg::ADDR_CFG_HI:
          o_rdata <= i_cfg_word[15:8];
        default:
          o_rdata <= 8'h00;
      endcase
    end
  end

endmodule

`default_nettype wire

/* tb/rts_seq_asserts.sv */
// Port-level assertion checker for the reset and time-out sequencer
`timescale 1ns/10ps
`default_nettype none

module rts_seq_checker (
  input wire logic i_clk_sys,
  input wire logic i_arst_n,
  input wire logic [15:0] i_cfg_word,
  input wire logic i_master_clear_n,
  input wire logic i_bod_low,
  input wire logic i_wdt_timeout,
  input wire logic i_sleep,
  input wire logic [7:0] i_addr,
  input wire logic i_rd,
  input wire logic [7:0] o_rdata,
  input wire logic o_core_rst_n,
  input wire logic o_run_on_internal_oscillator,
  input wire logic o_bod_enable
);
  // ------
  // Helpers
  // ------
  logic [2:0] up_cnt_r;
  logic [5:0] dip_cnt_r;
  logic up;
  logic [1:0] mode;
  assign up = (up_cnt_r == 3'h7);
  assign mode = i_cfg_word[9:8];

  // Outputs are forced low for a few cycles after release, so checks wait
  always_ff @(posedge i_clk_sys or negedge i_arst_n)
  begin
    if (!i_arst_n)
      up_cnt_r <= 3'h0;
    else if (!up)
      up_cnt_r <= up_cnt_r + 3'h1;
  end

  // Saturates so one long dip hits the check point once
  always_ff @(posedge i_clk_sys or negedge i_arst_n)
  begin
    if (!i_arst_n)
      dip_cnt_r <= 6'h00;
    else if (!(i_bod_low && o_bod_enable))
      dip_cnt_r <= 6'h00;
    else if (dip_cnt_r != 6'h3F)
      dip_cnt_r <= dip_cnt_r + 6'h01;
  end

  // ------
  // Properties
  // ------
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_arst_n);

  property p_bod_off;
    up && mode == 2'h0 |-> !o_bod_enable;
  endproperty
  a_bod_off: assert property (p_bod_off) else $error("detector on in mode 0");
  property p_bod_on;
    up && mode == 2'h3 |-> o_bod_enable;
  endproperty
  a_bod_on: assert property (p_bod_on) else $error("detector off in mode 3");
  property p_bod_sleep;
    up && mode == 2'h2 && i_sleep ##1 i_sleep |=> !o_bod_enable;
  endproperty
  a_bod_sleep: assert property (p_bod_sleep) else $error("detector on in sleep");
  property p_dip;
    dip_cnt_r == 6'h1E |-> !o_core_rst_n;
  endproperty
  a_dip: assert property (p_dip) else $error("long dip kept core running");
  property p_mclear;
    up && i_cfg_word[5] && !i_master_clear_n |-> ##[1:4] !o_core_rst_n;
  endproperty
  a_mclear: assert property (p_mclear) else $error("clear pin ignored");
  property p_wdt;
    up && i_wdt_timeout && !i_sleep && o_core_rst_n && i_master_clear_n && !i_bod_low
      |=> !o_core_rst_n ##1 o_core_rst_n;
  endproperty
  a_wdt: assert property (p_wdt) else $error("watchdog reset not one cycle");
  property p_pc_read;
    $past(i_rd) && $past(i_addr) == rts_pkg::ADDR_POWER_CONTROL
      |-> o_rdata[7:6] == 2'h0 && o_rdata[3:2] == 2'h0;
  endproperty
  a_pc_read: assert property (p_pc_read) else $error("power control spare bits set");
  property p_ext_fast;
    up_cnt_r == 3'h6 && {i_cfg_word[4], i_cfg_word[2:0]} == 4'hB && mode == 2'h0
      && i_master_clear_n |-> o_core_rst_n;
  endproperty
  a_ext_fast: assert property (p_ext_fast) else $error("start-up delay seen");

  c_wdt: cover property (i_wdt_timeout && o_core_rst_n);
  c_dip: cover property (dip_cnt_r == 6'h1E);
  c_internal_oscillator: cover property (o_run_on_internal_oscillator && o_core_rst_n);
endmodule

bind rts_reset_timeout_sequencer rts_seq_checker rts_seq_checker_inst (
  .i_clk_sys(i_clk_sys), .i_arst_n(i_arst_n), .i_cfg_word(i_cfg_word),
  .i_master_clear_n(i_master_clear_n), .i_bod_low(i_bod_low),
  .i_wdt_timeout(i_wdt_timeout), .i_sleep(i_sleep), .i_addr(i_addr), .i_rd(i_rd),
  .o_rdata(o_rdata), .o_core_rst_n(o_core_rst_n), .o_run_on_internal_oscillator(o_run_on_internal_oscillator),
  .o_bod_enable(o_bod_enable)
);

`default_nettype wire

/* tb/rts_testbench.sv */
// Self-checking testbench for the reset and time-out sequencer
`timescale 1ns/10ps
`default_nettype none

module testbench;
  localparam int DIV = 4;
  localparam int T_PWR = int'(rts_pkg::POWER_UP_TIMER_TICKS) * DIV;
  localparam int T_XTAL = int'(rts_pkg::OST_PERIODS) * 8;
  localparam logic [7:0] PC = rts_pkg::ADDR_POWER_CONTROL;
  localparam logic [7:0] ST = rts_pkg::ADDR_STATUS;
  logic clk, arst_n, mclear_n, bod, osc, wdt, slp, wr, rd;
  logic core_rst_n, stable, internal_oscillator, bod_en;
  logic [15:0] cfgw;
  logic [7:0] addr, wdata, rdata;
  int fails, checks;

  rts_reset_timeout_sequencer #(.P_LF_DIV_CYC(DIV)) rts_reset_timeout_sequencer_inst (
    .i_clk_sys(clk), .i_arst_n(arst_n), .i_cfg_word(cfgw), .i_master_clear_n(mclear_n),
    .i_bod_low(bod), .i_osc_clk(osc), .i_wdt_timeout(wdt), .i_sleep(slp),
    .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
    .o_core_rst_n(core_rst_n), .o_osc_stable(stable), .o_run_on_internal_oscillator(internal_oscillator),
    .o_bod_enable(bod_en)
  );

  always #2.5 clk = ~clk;
  // Crystal runs at 8 system cycles a period, well under the sync limit
  logic [1:0] osc_div = 2'h0;
  always @(posedge clk)
  begin
    osc_div <= osc_div + 2'h1;
    if (osc_div == 2'h3)
      osc <= ~osc;
  end

  // ------
  // Helpers
  // ------
  function automatic logic [15:0] cfg(input logic [2:0] o, input logic p, input logic [1:0] m,
                                      input logic t);
    return {5'h00, t, m, 3'h7, p, 1'h0, o};
  endfunction

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic close_out;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [7:0] mask, input logic [7:0] exp);
    addr <= a;
    rd <= 1'h1;
    @(posedge clk);
    rd <= 1'h0;
    @(negedge clk);
    chk(rdata & mask, exp);
    @(posedge clk);
  endtask

  task automatic wrt(input logic [7:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'h1;
    @(posedge clk);
    wr <= 1'h0;
    @(posedge clk);
  endtask

  // A wait that runs out ends the run at once
  task automatic wait_core(input int lim);
    int n;
    n = 0;
    checks++;
    while (core_rst_n !== 1'h1 && n < lim)
    begin
      @(negedge clk);
      n++;
    end
    if (core_rst_n !== 1'h1)
    begin
      fails++;
      close_out();
    end
    @(posedge clk);
  endtask

  task automatic wdt_kick(input logic exp_core);
    wdt <= 1'h1;
    @(posedge clk);
    wdt <= 1'h0;
    @(negedge clk);
    chk(core_rst_n, exp_core);
    @(posedge clk);
  endtask

  task automatic por(input logic [15:0] c);
    arst_n <= 1'h0;
    cfgw <= c;
    tick(4);
    arst_n <= 1'h1;
  endtask

  // ------
  // Scenarios
  // ------
  task automatic s_power_on;
    por(cfg(3'h3, 1'h1, 2'h0, 1'h0));
    wait_core(10);
    rdchk(PC, 8'hFF, 8'h10);
    rdchk(ST, 8'h18, 8'h18);
    rdchk(8'h40, 8'hFF, 8'h00);
    rdchk(rts_pkg::ADDR_CFG_LO, 8'hFF, 8'hF3);
    rdchk(rts_pkg::ADDR_CFG_HI, 8'hFF, 8'h00);
    wrt(ST, 8'h00);
    rdchk(ST, 8'h18, 8'h18);
    wrt(PC, 8'hFF);
    rdchk(PC, 8'hFF, 8'h33);
  endtask

  task automatic s_timer;
    por(cfg(3'h3, 1'h0, 2'h0, 1'h0));
    tick(T_PWR - 10);
    chk(core_rst_n, 1'h0);
    wait_core(40);
    wrt(PC, 8'h33);
    wdt_kick(1'h0);
    wait_core(4);
    rdchk(ST, 8'h18, 8'h08);
    rdchk(PC, 8'hFF, 8'h13);
    slp <= 1'h1;
    tick(3);
    wdt_kick(1'h1);
    slp <= 1'h0;
    rdchk(ST, 8'h18, 8'h00);
    slp <= 1'h1;
    mclear_n <= 1'h0;
    tick(8);
    slp <= 1'h0;
    mclear_n <= 1'h1;
    wait_core(10);
    rdchk(ST, 8'h18, 8'h10);
  endtask

  task automatic s_mclear_hold;
    mclear_n <= 1'h0;
    por(cfg(3'h3, 1'h0, 2'h0, 1'h0));
    tick(T_PWR + 40);
    chk(core_rst_n, 1'h0);
    mclear_n <= 1'h1;
    wait_core(6);
  endtask

  task automatic s_crystal;
    logic [15:0] c [3] = '{cfg(3'h1, 1'h0, 2'h0, 1'h0), cfg(3'h2, 1'h1, 2'h0, 1'h0),
                           cfg(3'h0, 1'h1, 2'h0, 1'h1)};
    int lo [3] = '{T_PWR + T_XTAL - 16, T_XTAL - 16, 0};
    for (int i = 0; i < 3; i++)
    begin
      por(c[i]);
      tick(lo[i]);
      chk(core_rst_n, 1'h0);
      wait_core(80);
      chk(internal_oscillator, i == 2);
      chk(stable, i != 2);
    end
    tick(T_XTAL + 40);
    chk(stable, 1'h1);
    chk(internal_oscillator, 1'h0);
  endtask

  task automatic s_brownout;
    bod <= 1'h1;
    por(cfg(3'h3, 1'h0, 2'h3, 1'h0));
    tick(T_PWR + 100);
    chk(core_rst_n, 1'h0);
    bod <= 1'h0;
    wait_core(T_PWR + 40);
    wrt(PC, 8'h13);
    bod <= 1'h1;
    tick(10);
    bod <= 1'h0;
    tick(40);
    chk(core_rst_n, 1'h1);
    bod <= 1'h1;
    tick(40);
    chk(core_rst_n, 1'h0);
    bod <= 1'h0;
    tick(2000);
    bod <= 1'h1;
    tick(40);
    bod <= 1'h0;
    tick(T_PWR - 20);
    chk(core_rst_n, 1'h0);
    wait_core(60);
    rdchk(PC, 8'hFF, 8'h12);
    rdchk(ST, 8'h18, 8'h18);
  endtask

  task automatic s_bod_modes;
    for (int m = 0; m < 4; m++)
    begin
      por(cfg(3'h3, 1'h1, 2'(m), 1'h0));
      wait_core(10);
      chk(bod_en, m != 0);
      wrt(PC, 8'h03);
      tick(2);
      chk(bod_en, m > 1);
      slp <= 1'h1;
      tick(4);
      chk(bod_en, m == 3);
      slp <= 1'h0;
      tick(4);
      chk(bod_en, m > 1);
      wrt(PC, 8'h13);
      tick(2);
      chk(bod_en, m != 0);
    end
  endtask

  initial
  begin
    clk = 1'h0;
    arst_n = 1'h0;
    mclear_n = 1'h1;
    bod = 1'h0;
    osc = 1'h0;
    wdt = 1'h0;
    slp = 1'h0;
    wr = 1'h0;
    rd = 1'h0;
    cfgw = 16'h0000;
    addr = 8'h00;
    wdata = 8'h00;
    fails = 0;
    checks = 0;
    tick(16);
    s_power_on();
    s_timer();
    s_mclear_hold();
    s_crystal();
    s_brownout();
    s_bod_modes();
    close_out();
  end
endmodule

`default_nettype wire
